/* pkg/pwm_timebase_regs.svh */
// register indices, field positions, reset values and counts for the time base
`ifndef PWM_TIMEBASE_REGS_SVH
`define PWM_TIMEBASE_REGS_SVH
`define IDX_EXT_RESET_SEL 14'h0460
`define IDX_CLOCK_SRC_SEL 14'h0461
`define IDX_AUTOLOAD_SEL 14'h0462
`define IDX_PERIOD_LOW 14'h0463
`define IDX_PERIOD_HIGH 14'h0464
`define IDX_PRESCALE 14'h0465
`define IDX_POSTSCALE 14'h0466
`define IDX_PARAM_IRQ 14'h0467
`define IDX_CONTROL 14'h0469
`define IDX_STATUS 14'h046A
`define CTL_EN 7
`define CTL_LD 2
`define CTL_ERSPOL 1
`define CTL_EXT_RESET_IMMEDIATE 0
`define STS_HELD 16
`define STS_LOAD 17
`define RST_BYTE 8'h00
`define RST_PERIOD 16'h0000
`define RST_SEL 4'h0
`define SYNC_STAGES 2
`define CLK_SYSTEM 4'h2
`define LDS_FIRST_OFF 4'hB
`define ERS_FIRST_OFF 4'hC
`define ERS_PIN 4'h1
`define ERS_CELL 4'h8
`define ERS_SLICE 4'h2
`define LDS_DMA 4'h7
`define LDS_CELL 4'h3
`endif

/* pkg/pwm_timebase_pkg.sv */
// shared types of the modulator time base
package pwm_timebase_pkg;
    typedef logic [15:0] count_t;
    typedef logic [7:0] byte_t;
    typedef logic [3:0] sel_t;
endpackage

/* pkg/timebase_if.sv */
// carrier between the register block and the period timer
`timescale 1ns/100ps
`default_nettype none
interface timebase_if;
    import pwm_timebase_pkg::*;
    logic run;
    logic tick;
    logic ers_active;
    logic ers_now;
    count_t period_buf;
    count_t count;
    logic held;
    logic period_evt;
    modport ctrl (output run, tick, ers_active, ers_now, period_buf, input count, held, period_evt);
    modport timer (input run, tick, ers_active, ers_now, period_buf, output count, held, period_evt);
endinterface
`default_nettype wire

/* verilog/trigger_sync.sv */
// two-stage synchroniser for a vector of asynchronous inputs
`timescale 1ns/100ps
`default_nettype none
module trigger_sync #(parameter int W = 1) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // raw and synchronised levels
    input wire logic [W-1:0] raw,
    output logic [W-1:0] synced
);
    logic [W-1:0] meta;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            meta <= '0;
            synced <= '0;
        end else begin
            meta <= raw;
            synced <= meta;
        end
    end
endmodule // trigger_sync
`default_nettype wire

/* verilog/period_timer.sv */
// period counter with external reset hold
`timescale 1ns/100ps
`default_nettype none
module period_timer (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // configuration and state
    timebase_if.timer tb
);
    logic at_end;
    assign at_end = (tb.count == tb.period_buf);
    always_ff @(posedge sys_clk) begin
        if (!resetn || !tb.run) begin
            tb.count <= 16'h0000;
            tb.held <= 1'b0;
        end else if (!tb.ers_active) begin
            tb.held <= 1'b0;
            if (tb.tick) begin
                tb.count <= at_end ? 16'h0000 : tb.count + 16'h0001;
            end
        end else if (tb.tick && (tb.ers_now || tb.held || at_end)) begin
            tb.count <= 16'h0000;
            tb.held <= 1'b1;
        end else if (tb.tick) begin
            tb.count <= tb.count + 16'h0001;
        end
    end
    // a period reset event is the rollover at the period value
    always_ff @(posedge sys_clk) begin
        if (!resetn || !tb.run) begin
            tb.period_evt <= 1'b0;
        end else begin
            tb.period_evt <= tb.tick && at_end && !tb.held;
        end
    end
endmodule // period_timer
`default_nettype wire

/* verilog/pwm_timebase_config.sv */
// register block, source selection, prescaler and postscaler of the modulator time base
`timescale 1ns/100ps
`default_nettype none
`include "pwm_timebase_regs.svh"
module pwm_timebase_config
    import pwm_timebase_pkg::*;
#(
    parameter int INSTANCE = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // trigger and clock sources, asynchronous
    input wire logic ext_reset_pin_input,
    input wire logic pin_input_zero,
    input wire logic pin_input_one,
    input wire logic [3:0] logic_cell_out,
    input wire logic [5:0] slice_out,
    input wire logic [3:0] dma_count_done,
    input wire logic [15:0] clock_sources,
    input wire logic sleep,
    // time base results
    output logic module_enabled,
    output logic prescaled_tick,
    output logic period_reset_evt,
    output logic period_irq,
    output count_t timer_count
);

    ////////////////////////////////////////////////////////////////////////
    // register state

    sel_t ext_reset_sel;
    sel_t clock_src_sel;
    sel_t autoload_sel;
    count_t period_val;
    byte_t prescale_val;
    byte_t postscale_val;
    logic enable;
    logic load_request;
    logic ers_polarity_low;
    logic ext_reset_immediate;
    timebase_if tb ();

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    logic [13:0] index;
    logic aligned;
    logic setup_phase;
    logic wr_strobe;
    logic hit;

    assign index = paddr[15:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign setup_phase = psel && !penable;
    // zero wait states: the answer is prepared during setup
    assign pready = 1'b1;
    assign wr_strobe = psel && penable && pwrite && !pslverr;

    function automatic logic is_reg(input logic [13:0] idx, input logic [13:0] want);
        is_reg = (idx == want);
    endfunction

    function automatic logic mapped(input logic [13:0] idx);
        mapped = is_reg(idx, `IDX_EXT_RESET_SEL) || is_reg(idx, `IDX_CLOCK_SRC_SEL)
            || is_reg(idx, `IDX_AUTOLOAD_SEL) || is_reg(idx, `IDX_PERIOD_LOW)
            || is_reg(idx, `IDX_PERIOD_HIGH) || is_reg(idx, `IDX_PRESCALE)
            || is_reg(idx, `IDX_POSTSCALE) || is_reg(idx, `IDX_PARAM_IRQ)
            || is_reg(idx, `IDX_CONTROL) || is_reg(idx, `IDX_STATUS);
    endfunction

    function automatic logic wr_to(input logic [13:0] want);
        wr_to = wr_strobe && is_reg(index, want);
    endfunction

    assign hit = aligned && mapped(index);

    ////////////////////////////////////////////////////////////////////////
    // configuration writes

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ext_reset_sel <= `RST_SEL;
        end else if (wr_to(`IDX_EXT_RESET_SEL)) begin
            ext_reset_sel <= pwdata[3:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            clock_src_sel <= `RST_SEL;
        end else if (wr_to(`IDX_CLOCK_SRC_SEL)) begin
            clock_src_sel <= pwdata[3:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            autoload_sel <= `RST_SEL;
        end else if (wr_to(`IDX_AUTOLOAD_SEL)) begin
            autoload_sel <= pwdata[3:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            period_val <= `RST_PERIOD;
        end else if (wr_to(`IDX_PERIOD_LOW)) begin
            period_val[7:0] <= pwdata[7:0];
        end else if (wr_to(`IDX_PERIOD_HIGH)) begin
            period_val[15:8] <= pwdata[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            prescale_val <= `RST_BYTE;
        end else if (wr_to(`IDX_PRESCALE)) begin
            prescale_val <= pwdata[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            postscale_val <= `RST_BYTE;
        end else if (wr_to(`IDX_POSTSCALE)) begin
            postscale_val <= pwdata[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            enable <= 1'b0;
            ers_polarity_low <= 1'b0;
            ext_reset_immediate <= 1'b0;
        end else if (wr_to(`IDX_CONTROL)) begin
            enable <= pwdata[`CTL_EN];
            ers_polarity_low <= pwdata[`CTL_ERSPOL];
            ext_reset_immediate <= pwdata[`CTL_EXT_RESET_IMMEDIATE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, registered in the setup phase

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            pslverr <= !hit;
            prdata <= 32'h00000000;
            if (!pwrite && hit) begin
                unique case (index)
                    `IDX_EXT_RESET_SEL: prdata[3:0] <= ext_reset_sel;
                    `IDX_CLOCK_SRC_SEL: prdata[3:0] <= clock_src_sel;
                    `IDX_AUTOLOAD_SEL: prdata[3:0] <= autoload_sel;
                    `IDX_PERIOD_LOW: prdata[7:0] <= period_val[7:0];
                    `IDX_PERIOD_HIGH: prdata[7:0] <= period_val[15:8];
                    `IDX_PRESCALE: prdata[7:0] <= prescale_val;
                    `IDX_POSTSCALE: prdata[7:0] <= postscale_val;
                    `IDX_CONTROL: prdata[7:0] <= {enable, 4'h0, load_request,
                        ers_polarity_low, ext_reset_immediate};
                    `IDX_STATUS: prdata[17:0] <= {load_request, tb.held, tb.count};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // synchronisers for every outside level except sleep, which gates the system clock tick directly

    logic [15:0] sync_clk;
    logic [15:0] sync_trig;

    trigger_sync #(.W(16)) clk_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .raw(clock_sources),
        .synced(sync_clk)
    );

    trigger_sync #(.W(16)) trig_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .raw({pin_input_one, pin_input_zero, slice_out, dma_count_done, logic_cell_out}),
        .synced(sync_trig)
    );

    logic [3:0] cell_s;
    logic [3:0] dma_s;
    logic [5:0] slice_s;
    logic pin0_s;
    logic pin1_s;
    logic ers_pin_s;

    assign cell_s = sync_trig[3:0];
    assign dma_s = sync_trig[7:4];
    assign slice_s = sync_trig[13:8];
    assign pin0_s = sync_trig[14];
    assign pin1_s = sync_trig[15];

    logic ext_reset_pin_input_s;
    logic ers_pin_meta;
    // the external reset pin has its own two flops, the shared vector being full
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ers_pin_meta <= 1'b0;
            ext_reset_pin_input_s <= 1'b0;
        end else begin
            ers_pin_meta <= ext_reset_pin_input;
            ext_reset_pin_input_s <= ers_pin_meta;
        end
    end
    assign ers_pin_s = ext_reset_pin_input_s;

    ////////////////////////////////////////////////////////////////////////
    // external reset source

    logic ers_raw;
    logic [3:0] ers_slice_idx;
    logic ers_own;

    assign ers_slice_idx = ext_reset_sel - `ERS_SLICE;
    // codes naming this instance's own slice outputs are reserved
    assign ers_own = (ext_reset_sel[3:1] == 3'(INSTANCE));

    always_comb begin
        ers_raw = 1'b0;
        if (ext_reset_sel == `ERS_PIN) begin
            ers_raw = ers_pin_s;
        end else if (ext_reset_sel >= `ERS_FIRST_OFF) begin
            ers_raw = 1'b0;
        end else if (ext_reset_sel >= `ERS_CELL) begin
            ers_raw = cell_s[ext_reset_sel[1:0]];
        end else if (ext_reset_sel >= `ERS_SLICE && !ers_own) begin
            ers_raw = slice_s[ers_slice_idx[2:0]];
        end
    end

    logic ers_selected;
    // own slice codes count as disabled, else an active-low polarity would hold the timer
    assign ers_selected = (ext_reset_sel != `RST_SEL) && (ext_reset_sel < `ERS_FIRST_OFF) && !ers_own;

    ////////////////////////////////////////////////////////////////////////
    // auto-load trigger source

    logic lds_raw;
    logic lds_prev;
    logic lds_rise;
    logic [3:0] lds_dma_idx;
    logic [3:0] lds_cell_idx;

    assign lds_dma_idx = autoload_sel - `LDS_DMA;
    assign lds_cell_idx = autoload_sel - `LDS_CELL;

    always_comb begin
        lds_raw = 1'b0;
        if (autoload_sel == `RST_SEL || autoload_sel >= `LDS_FIRST_OFF) begin
            lds_raw = 1'b0;
        end else if (autoload_sel >= `LDS_DMA) begin
            lds_raw = dma_s[lds_dma_idx[1:0]];
        end else if (autoload_sel >= `LDS_CELL) begin
            lds_raw = cell_s[lds_cell_idx[1:0]];
        end else begin
            lds_raw = autoload_sel[1] ? pin1_s : pin0_s;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            lds_prev <= 1'b0;
        end else begin
            lds_prev <= lds_raw;
        end
    end

    assign lds_rise = lds_raw && !lds_prev;

    ////////////////////////////////////////////////////////////////////////
    // clock source and prescaler

    logic src_prev;
    logic src_tick;
    logic [7:0] pre_cnt;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            src_prev <= 1'b0;
        end else begin
            src_prev <= sync_clk[clock_src_sel];
        end
    end

    // only the system clock stops while asleep; other sources run on
    assign src_tick = (clock_src_sel == `CLK_SYSTEM) ? !sleep : (sync_clk[clock_src_sel] && !src_prev);

    always_ff @(posedge sys_clk) begin
        if (!resetn || !enable) begin
            pre_cnt <= 8'h00;
        end else if (src_tick) begin
            pre_cnt <= (pre_cnt == prescale_val) ? 8'h00 : pre_cnt + 8'h01;
        end
    end

    assign tb.tick = enable && src_tick && (pre_cnt == prescale_val);

    ////////////////////////////////////////////////////////////////////////
    // period timer and double buffer

    assign tb.run = enable;
    assign tb.ers_active = ers_selected && (ers_raw ^ ers_polarity_low);
    assign tb.ers_now = ext_reset_immediate;

    period_timer timer (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .tb(tb.timer)
    );

    // load stays pending until consumed; a new request in the consume cycle wins
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            load_request <= 1'b0;
        end else if ((wr_to(`IDX_CONTROL) && pwdata[`CTL_LD]) || lds_rise) begin
            load_request <= 1'b1;
        end else if (tb.period_evt && enable) begin
            load_request <= 1'b0;
        end
    end

    // while disabled the buffer follows the register, so enabling starts clean
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tb.period_buf <= `RST_PERIOD;
        end else if (!enable || (tb.period_evt && load_request)) begin
            tb.period_buf <= period_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // postscaler and outputs

    logic [7:0] post_cnt;

    always_ff @(posedge sys_clk) begin
        if (!resetn || !enable || tb.held) begin
            post_cnt <= 8'h00;
        end else if (tb.period_evt) begin
            post_cnt <= (post_cnt == postscale_val) ? 8'h00 : post_cnt + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn || !enable) begin
            period_irq <= 1'b0;
            period_reset_evt <= 1'b0;
            prescaled_tick <= 1'b0;
        end else begin
            period_irq <= tb.period_evt && (post_cnt == postscale_val);
            period_reset_evt <= tb.period_evt;
            prescaled_tick <= tb.tick;
        end
    end

    assign timer_count = tb.count;
    assign module_enabled = enable;

endmodule // pwm_timebase_config
`default_nettype wire

/* testbench/pwm_timebase_config_asserts.sv */
// concurrent checks on the ports of the modulator time base
`timescale 1ns/100ps
`default_nettype none
`include "pwm_timebase_regs.svh"
module pwm_timebase_config_asserts
    import pwm_timebase_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // time base results
    input wire logic module_enabled,
    input wire logic prescaled_tick,
    input wire logic period_reset_evt,
    input wire logic period_irq,
    input wire count_t timer_count
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    logic [13:0] idx;
    logic acc;
    logic mapped;
    byte_t lo;
    byte_t hi;
    assign idx = paddr[15:2];
    assign acc = psel && penable;
    assign mapped = paddr[1:0] == 2'h0 &&
        (idx inside {[`IDX_EXT_RESET_SEL:`IDX_PARAM_IRQ], `IDX_CONTROL, `IDX_STATUS});
    // shadow of the period bytes; unaligned writes never land, so only exact addresses count
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            lo <= `RST_BYTE;
            hi <= `RST_BYTE;
        end else if (acc && pwrite && paddr == {`IDX_PERIOD_LOW, 2'h0}) begin
            lo <= pwdata[7:0];
        end else if (acc && pwrite && paddr == {`IDX_PERIOD_HIGH, 2'h0}) begin
            hi <= pwdata[7:0];
        end
    end
    ////////////////////////////////////////////////////////////
    a_ready_always: assert property (psel |-> pready)
        else $error("pready low in a transfer");
    a_err_decode: assert property (acc |-> pslverr == !mapped)
        else $error("pslverr does not match address decode");
    a_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_low_readback: assert property (
        acc && !pwrite && paddr == {`IDX_PERIOD_LOW, 2'h0} |-> prdata == {24'h00_0000, lo})
        else $error("period low byte read wrong");
    a_high_readback: assert property (
        acc && !pwrite && paddr == {`IDX_PERIOD_HIGH, 2'h0} |-> prdata == {24'h00_0000, hi})
        else $error("period high byte read wrong");
    a_reset_clear: assert property ($rose(resetn) |-> timer_count == 16'h0000 && !module_enabled)
        else $error("outputs not cleared by reset");
    a_enable_mirror: assert property (
        acc && pwrite && paddr == {`IDX_CONTROL, 2'h0} |=> module_enabled == $past(pwdata[`CTL_EN]))
        else $error("enable flag does not follow write");
    a_count_step: assert property (
        $changed(timer_count) |-> timer_count == 16'h0000 || timer_count == $past(timer_count) + 16'h0001)
        else $error("timer skipped a value");
    a_idle_off: assert property (!module_enabled [*6] |-> !prescaled_tick && !period_reset_evt && !period_irq)
        else $error("activity while disabled");
    a_irq_on_evt: assert property (period_irq |-> period_reset_evt || $past(period_reset_evt))
        else $error("period interrupt without period event");
endmodule // pwm_timebase_config_asserts
`default_nettype wire

/* testbench/pwm_timebase_config_test.sv */
// self-checking bench for the modulator time base
`timescale 1ns/100ps
`default_nettype none
`include "pwm_timebase_regs.svh"
module pwm_timebase_config_test
    import pwm_timebase_pkg::*;
;
    logic sys_clk, resetn, psel, penable, pwrite, sleep, ers_pin;
    logic [1:0] pins;
    logic pready, pslverr, module_enabled, prescaled_tick, period_reset_evt, period_irq, rerr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] logic_cell_out, dma_count_done;
    count_t timer_count;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int g;
    // peer slices and clock pins stay tied; their paths are left to the system bench
    pwm_timebase_config i_dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_reset_pin_input(ers_pin), .pin_input_zero(pins[0]), .pin_input_one(pins[1]),
        .logic_cell_out(logic_cell_out), .slice_out(6'h00), .dma_count_done(dma_count_done),
        .clock_sources(16'h0000), .sleep(sleep), .module_enabled(module_enabled),
        .prescaled_tick(prescaled_tick), .period_reset_evt(period_reset_evt),
        .period_irq(period_irq), .timer_count(timer_count));
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////
    task conclude;
        if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task apb(input logic wr, input logic [15:0] addr, input logic [31:0] wd);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'h1;
        do @(posedge sys_clk); while (pready !== 1'h1);
        rdat = prdata;
        rerr = pslverr;
        chk("pready", 32'h1, {31'h0, pready});
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge sys_clk);
    endtask
    task wr(input logic [13:0] i, input logic [31:0] d);
        apb(1'h1, {i, 2'h0}, d);
    endtask
    task rd(input logic [13:0] i, input string what, input logic [31:0] exp);
        apb(1'h0, {i, 2'h0}, 32'h0);
        chk(what, exp, rdat);
        chk("pslverr", 32'h0, {31'h0, rerr});
    endtask
    // cycles between two pulses of a result: 0 tick, 1 period event, 2 interrupt
    task gap(input int w, input int exp, input string what);
        int n;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin @(posedge sys_clk); n++; end
            while ((w == 0 ? prescaled_tick : w == 1 ? period_reset_evt : period_irq) !== 1'h1 && n < 600);
        end
        chk(what, exp, n);
    endtask
    task count_ticks(input string what);
        g = 0;
        repeat (30) begin @(posedge sys_clk); if (prescaled_tick === 1'h1) g++; end
        chk(what, 32'h0, g);
    endtask
    ////////////////////////////////////////////////////////////
    task s_regs;
        for (int i = 0; i < 7; i++) begin
            rd(`IDX_EXT_RESET_SEL + 14'(i), "reset value", 32'h0);
            wr(`IDX_EXT_RESET_SEL + 14'(i), 32'hFFFF_FFA5);
            rd(`IDX_EXT_RESET_SEL + 14'(i), "read back", i < 3 ? 32'h5 : 32'hA5);
        end
        wr(`IDX_PARAM_IRQ, 32'hFF);
        rd(`IDX_PARAM_IRQ, "flags place", 32'h0);
        apb(1'h0, 16'h11C0, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, rerr});
        apb(1'h1, {`IDX_PRESCALE, 2'h1}, 32'h7);
        chk("unaligned err", 32'h1, {31'h0, rerr});
        rd(`IDX_PRESCALE, "unaligned ignored", 32'hA5);
    endtask
    task s_time;
        wr(`IDX_EXT_RESET_SEL, 32'h0);
        wr(`IDX_AUTOLOAD_SEL, 32'h0);
        wr(`IDX_CLOCK_SRC_SEL, `CLK_SYSTEM);
        wr(`IDX_PERIOD_LOW, 32'h3);
        wr(`IDX_PERIOD_HIGH, 32'h0);
        wr(`IDX_PRESCALE, 32'h2);
        wr(`IDX_POSTSCALE, 32'h1);
        wr(`IDX_CONTROL, 32'h80);
        gap(0, 3, "tick spacing");
        gap(1, 12, "period spacing");
        gap(2, 24, "irq spacing");
        sleep <= 1'h1;
        @(posedge sys_clk);
        count_ticks("ticks asleep");
        sleep <= 1'h0;
    endtask
    task s_ers;
        wr(`IDX_EXT_RESET_SEL, `ERS_CELL);
        wr(`IDX_CONTROL, 32'h81);
        logic_cell_out <= 4'h1;
        repeat (10) @(posedge sys_clk);
        g = 0;
        repeat (40) begin @(posedge sys_clk); if (timer_count !== 16'h0 || period_reset_evt !== 1'h0) g++; end
        chk("held cycles", 32'h0, g);
        rd(`IDX_STATUS, "held status", 32'h0001_0000);
        logic_cell_out <= 4'h0;
        gap(1, 12, "after release");
        wr(`IDX_CONTROL, 32'h83);
        for (int c = 0; c < 4; c++) begin
            wr(`IDX_EXT_RESET_SEL, c == 0 ? 32'h0 : c == 1 ? 32'hC : c == 2 ? 32'hF : 32'h2);
            logic_cell_out <= 4'hF;
            gap(1, 12, "ers disabled");
            logic_cell_out <= 4'h0;
        end
        wr(`IDX_EXT_RESET_SEL, 32'h9);
        wr(`IDX_CONTROL, 32'h83);
        repeat (10) @(posedge sys_clk);
        rd(`IDX_STATUS, "low active hold", 32'h0001_0000);
        logic_cell_out <= 4'h2;
        gap(1, 12, "low active release");
        wr(`IDX_EXT_RESET_SEL, 32'h1);
        repeat (10) @(posedge sys_clk);
        rd(`IDX_STATUS, "pin hold", 32'h0001_0000);
        ers_pin <= 1'h1;
        gap(1, 12, "pin release");
        ers_pin <= 1'h0;
        wr(`IDX_EXT_RESET_SEL, 32'h0);
        wr(`IDX_CONTROL, 32'h80);
        logic_cell_out <= 4'h0;
    endtask
    task s_load;
        wr(`IDX_PERIOD_LOW, 32'h5);
        gap(1, 12, "unloaded period");
        wr(`IDX_CONTROL, 32'h84);
        repeat (30) @(posedge sys_clk);
        gap(1, 18, "software load");
        rd(`IDX_CONTROL, "load cleared", 32'h80);
        for (int k = 1; k < 13; k++) begin
            wr(`IDX_PERIOD_LOW, k[0] ? 32'h3 : 32'h5);
            wr(`IDX_AUTOLOAD_SEL, k > 10 ? 32'hB : 32'(k));
            if (k > 10) dma_count_done <= 4'hF;
            else if (k < 3) pins <= 2'(k);
            else if (k < 7) logic_cell_out <= 4'(1 << (k - 3));
            else dma_count_done <= 4'(1 << (k - 7));
            repeat (4) @(posedge sys_clk);
            logic_cell_out <= 4'h0;
            dma_count_done <= 4'h0;
            pins <= 2'h0;
            repeat (30) @(posedge sys_clk);
            gap(1, k > 10 ? 18 : k[0] ? 12 : 18, "auto load");
        end
    endtask
    task s_enable;
        wr(`IDX_CONTROL, 32'h0);
        chk("enable flag", 32'h0, {31'h0, module_enabled});
        rd(`IDX_PRESCALE, "prescale kept", 32'h2);
        rd(`IDX_PERIOD_LOW, "period kept", 32'h5);
        count_ticks("ticks while off");
        wr(`IDX_CONTROL, 32'h80);
        g = 0;
        do begin @(posedge sys_clk); if (period_reset_evt === 1'h1) g++; end
        while (period_irq !== 1'h1 && g < 10);
        chk("events to first irq", 32'h2, g);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'h0;
        resetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        sleep = 1'h0;
        ers_pin = 1'h0;
        pins = 2'h0;
        logic_cell_out = 4'h0;
        dma_count_done = 4'h0;
        repeat (20) @(posedge sys_clk);
        resetn <= 1'h1;
        @(posedge sys_clk);
        s_regs();
        s_time();
        s_ers();
        s_load();
        s_enable();
        conclude();
    end
endmodule // pwm_timebase_config_test
bind pwm_timebase_config pwm_timebase_config_asserts i_chk (.sys_clk(sys_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .module_enabled(module_enabled),
    .prescaled_tick(prescaled_tick), .period_reset_evt(period_reset_evt),
    .period_irq(period_irq), .timer_count(timer_count));
`default_nettype wire
